// *** design/bus_window_master.sv ***
// Local decode and system-bus access sequencer of the interrupt pre-processor.
// Assumes local strobes are levels held until O_READY is seen and then
// dropped; bus inputs are synchronous to I_REF_CLK.
//
// Contract
// - Memory accesses at C000-FFFF go to system bus memory, not local resources.
// - Bus address: bits 0-7 from local address, bits 8-23 from stored registers.
// - Software loads middle then upper address byte before touching the window.
// - Window read runs bus memory read; window write runs bus memory write.
// - Opcode fetches inside the window are also run on the bus.
// - Local address bits 8-15 are ignored inside the window.
// - Local registers are memory mapped; every local I/O cycle goes to bus.
// - Bus I/O address: port number low, middle address register high.
// - Local input runs bus input cycle; local output runs bus output cycle.
// - Device requests, arbitrates and runs each bus cycle, one at a time.
// - Local processor waits until the bus access has finished.
// - System output to call port raises restart 7.5; no data taken.
// - Call port compared with switch; position 1 is bit 7, closed is 0.
// - Serial output mode: bus request follows the serial output line.
// - Latch mode: read of 8002 sets latch; acknowledge cycle clears it.
// - Request source is routed to at most one of ten bus lines; jumper codes 10-15 select none.
// - With response enabled, stored byte is driven during acknowledge cycles.
// - Option 1 closed adds EPROM wait; option 2 closed enables response.
// - Options 3 to 6 give 4-bit arbitration priority, 3 most significant.
// - Option 7 closed lets SLAVE CLR reset the device; open ignores it.
// - At power-on RAM and EPROM ranges swap so first fetches hit EPROM; code maps EPROM into both ranges.
`timescale 1ns/1ps
module bus_window_master (
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  // Local processor
  input  wire logic [15:0] I_LA,
  input  wire logic [7:0]  I_LD,
  input  wire logic        I_MEM_RD,
  input  wire logic        I_MEM_WR,
  input  wire logic        I_IO_RD,
  input  wire logic        I_IO_WR,
  input  wire logic        I_FETCH,
  input  wire logic        I_SERIAL_OUTPUT_LINE,
  output logic      [7:0]  o_ld_unused_guard,
  output logic      [7:0]  O_LD,
  output logic             O_READY,
  output logic             O_RESTART75,
  // Local chip selects
  output logic             O_RAM_SEL,
  output logic             O_ROM_SEL,
  output logic             O_IRQ_CTRL_SEL,
  // Switches and jumpers
  input  wire logic [7:0]  I_CALL_PORT_SWITCH,
  input  wire logic [7:0]  I_OPTION_SWITCH,
  input  wire logic [3:0]  I_REQUEST_ROUTE_JUMPERS,
  input  wire logic        I_ROUTE_FROM_LATCH,
  // Bus mastership
  output logic             O_HOLD_OE,
  input  wire logic        I_PHLDA,
  input  wire logic [3:0]  I_DMA_ASSERTED,
  output logic      [3:0]  O_DMA_OE,
  input  wire logic        I_RDY,
  // Bus cycle as master
  output logic      [23:0] O_BUS_ADDR,
  output logic      [7:0]  O_BUS_DO,
  input  wire logic [7:0]  I_BUS_DI,
  output logic             O_SMEMR,
  output logic             O_MWRT,
  output logic             O_SINP,
  output logic             O_SOUT,
  output logic             O_SM1,
  output logic             O_PDBIN,
  output logic             O_PWR,
  // Bus cycle as slave
  input  wire logic [7:0]  I_SYS_A,
  input  wire logic        I_SYS_SOUT,
  input  wire logic        I_SYS_PWR,
  input  wire logic        I_SYS_SINTA,
  input  wire logic        I_SYS_PDBIN,
  input  wire logic        I_SLAVE_CLR_N,
  output logic      [7:0]  O_ACK_DATA,
  output logic             O_ACK_DATA_OE,
  // Interrupt request lines (open drain, pulled low while enabled)
  output logic      [7:0]  O_VI_OE,
  output logic             O_NMI_OE,
  output logic             O_INT_OE
);

  // ---------------------------------------------------------------------------
  // Reset and options
  // ---------------------------------------------------------------------------
  logic       rst;
  logic       rom_wait_en;
  logic       resp_en;
  logic [3:0] priority_sw;

  assign rst         = I_RST | (~I_OPTION_SWITCH[bwm_pkg::OPT_SLAVE_CLR]
                                & ~I_SLAVE_CLR_N);
  assign rom_wait_en = ~I_OPTION_SWITCH[bwm_pkg::OPT_ROM_WAIT];
  assign resp_en     = ~I_OPTION_SWITCH[bwm_pkg::OPT_RESP_EN];
  assign priority_sw = {<<{~I_OPTION_SWITCH[bwm_pkg::OPT_PRI_MSB +: 4]}};
  assign o_ld_unused_guard = 8'h00;

  // ---------------------------------------------------------------------------
  // Local decode
  // ---------------------------------------------------------------------------
  logic       swap;
  logic       mem_cyc;
  logic [1:0] region;
  logic       win_cyc;
  logic       io_cyc;
  logic       bus_cyc;

  assign mem_cyc = I_MEM_RD | I_MEM_WR;
  assign io_cyc  = I_IO_RD | I_IO_WR;
  assign region  = I_LA[15:14];
  assign win_cyc = mem_cyc & (region == bwm_pkg::WINDOW_REGION);
  assign bus_cyc = win_cyc | io_cyc;

  // Swapped map sends the low range to EPROM until EPROM's home range is hit
  always_comb begin
    O_RAM_SEL      = 1'b0;
    O_ROM_SEL      = 1'b0;
    O_IRQ_CTRL_SEL = 1'b0;
    if (mem_cyc) begin
      if (region == bwm_pkg::RAM_REGION) begin
        O_RAM_SEL = ~swap;
        O_ROM_SEL = swap;
      end else if (region == bwm_pkg::ROM_REGION) begin
        O_ROM_SEL = 1'b1;
      end else if (region == bwm_pkg::PERIPH_REGION) begin
        O_IRQ_CTRL_SEL = (I_LA == bwm_pkg::IRQ_CONTROLLER_PORT_LOW) |
                         (I_LA == bwm_pkg::IRQ_CONTROLLER_PORT_HIGH);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Local registers
  // ---------------------------------------------------------------------------
  logic [7:0] addr_mid;
  logic [7:0] addr_up;
  logic [7:0] resp_byte;
  logic       wr_prev;
  logic       rd_prev;
  logic       req_latch;
  logic       ack_prev;
  logic       call_prev;
  logic       rom_waited;
  logic [7:0] next_addr_mid;
  logic [7:0] next_addr_up;
  logic [7:0] next_resp_byte;
  logic       next_swap;
  logic       next_req_latch;
  logic       next_rom_waited;
  logic       wr_edge;
  logic       rd_edge;
  logic       ack_now;
  logic       call_now;

  assign wr_edge  = I_MEM_WR & ~wr_prev;
  assign rd_edge  = I_MEM_RD & ~rd_prev;
  assign ack_now  = I_SYS_SINTA & I_SYS_PDBIN;
  // Switch closed reads 0, so the switch bus is the address bit pattern
  assign call_now = I_SYS_SOUT & I_SYS_PWR & (I_SYS_A == I_CALL_PORT_SWITCH);

  always_comb begin
    next_addr_mid   = addr_mid;
    next_addr_up    = addr_up;
    next_resp_byte  = resp_byte;
    next_swap       = swap;
    next_req_latch  = req_latch;
    next_rom_waited = rom_waited;
    if (wr_edge && I_LA == bwm_pkg::BUS_ADDRESS_MIDDLE) begin
      next_addr_mid = I_LD;
    end
    if (wr_edge && I_LA == bwm_pkg::BUS_ADDRESS_UPPER) begin
      next_addr_up = I_LD;
    end
    if (wr_edge && I_LA == bwm_pkg::ACKNOWLEDGE_RESPONSE_BYTE) begin
      next_resp_byte = I_LD;
    end
    if (mem_cyc && region == bwm_pkg::ROM_REGION) begin
      next_swap = 1'b0;
    end
    // Clear on acknowledge first so a set in the same cycle wins
    if (ack_now && !ack_prev) begin
      next_req_latch = 1'b0;
    end
    if (rd_edge && I_LA == bwm_pkg::SET_REQUEST_LATCH) begin
      next_req_latch = 1'b1;
    end
    next_rom_waited = O_ROM_SEL;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (rst) begin
      addr_mid   <= bwm_pkg::BUS_ADDRESS_RESET;
      addr_up    <= bwm_pkg::BUS_ADDRESS_RESET;
      resp_byte  <= bwm_pkg::RESPONSE_RESET;
      swap       <= 1'b1;
      req_latch  <= 1'b0;
      rom_waited <= 1'b0;
      wr_prev    <= 1'b0;
      rd_prev    <= 1'b0;
      ack_prev   <= 1'b0;
      call_prev  <= 1'b0;
    end else begin
      addr_mid   <= next_addr_mid;
      addr_up    <= next_addr_up;
      resp_byte  <= next_resp_byte;
      swap       <= next_swap;
      req_latch  <= next_req_latch;
      rom_waited <= next_rom_waited;
      wr_prev    <= I_MEM_WR;
      rd_prev    <= I_MEM_RD;
      ack_prev   <= ack_now;
      call_prev  <= call_now;
    end
  end

  // ---------------------------------------------------------------------------
  // Call port and system interrupt request
  // ---------------------------------------------------------------------------
  logic req_src;

  // One pulse per system output cycle; the data lines are never sampled
  assign O_RESTART75 = call_now & ~call_prev;
  assign req_src     = I_ROUTE_FROM_LATCH ? req_latch : I_SERIAL_OUTPUT_LINE;
  assign O_NMI_OE    = req_src & (I_REQUEST_ROUTE_JUMPERS == bwm_pkg::ROUTE_NMI);
  assign O_INT_OE    = req_src & (I_REQUEST_ROUTE_JUMPERS == bwm_pkg::ROUTE_INT);

  genvar v;
  generate
    for (v = 0; v < 8; v++) begin : g_vi
      assign O_VI_OE[v] = req_src & (I_REQUEST_ROUTE_JUMPERS == 4'(v));
    end
  endgenerate

  // Only the single stored byte is offered, on every acknowledge cycle while response is enabled
  assign O_ACK_DATA    = resp_byte;
  assign O_ACK_DATA_OE = resp_en & ack_now;

  // ---------------------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------------------
  bwm_pkg::bus_state_t state;
  bwm_pkg::bus_state_t next_state;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic [23:0] next_bus_addr;
  logic [7:0]  next_bus_do;
  logic [7:0]  next_ld;
  logic [4:0]  strobes;
  logic [4:0]  next_strobes;
  logic        arb_en;
  logic        arb_win;

  assign arb_en = (state == bwm_pkg::ST_ARB);

  bwm_arbiter u_arbiter (
    .i_enable        (arb_en),
    .i_priority      (priority_sw),
    .i_line_asserted (I_DMA_ASSERTED),
    .o_line_oe       (O_DMA_OE),
    .o_win           (arb_win)
  );

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_bus_addr = O_BUS_ADDR;
    next_bus_do   = O_BUS_DO;
    next_ld       = O_LD;
    next_strobes  = strobes;
    unique case (state)
      bwm_pkg::ST_IDLE: begin
        if (bus_cyc) begin
          next_state    = bwm_pkg::ST_REQ;
          next_bus_addr = {addr_up, addr_mid, I_LA[7:0]};
          if (io_cyc) begin
            next_bus_addr = {8'h00, addr_mid, I_LA[7:0]};
          end
          next_bus_do   = I_LD;
          // Strobe order: memory read, memory write, input, output, fetch
          next_strobes  = {win_cyc & I_FETCH, I_IO_WR, I_IO_RD,
                           win_cyc & I_MEM_WR, win_cyc & I_MEM_RD};
        end
      end
      bwm_pkg::ST_REQ: begin
        if (I_PHLDA) begin
          next_state = bwm_pkg::ST_ARB;
          next_cnt   = 3'(bwm_pkg::ARB_SETTLE_CYC);
        end
      end
      bwm_pkg::ST_ARB: begin
        if (cnt != 3'h0) begin
          next_cnt = cnt - 3'h1;
        end else if (arb_win) begin
          next_state = bwm_pkg::ST_RUN;
          next_cnt   = 3'(bwm_pkg::STROBE_CYC);
        end
      end
      bwm_pkg::ST_RUN: begin
        if (cnt != 3'h0) begin
          next_cnt = cnt - 3'h1;
        end else if (I_RDY) begin
          next_state = bwm_pkg::ST_DONE;
          next_ld    = I_BUS_DI;
        end
      end
      bwm_pkg::ST_DONE: begin
        // Bus is released for each cycle; wait for the local strobe to drop
        if (!bus_cyc) begin
          next_state   = bwm_pkg::ST_IDLE;
          next_strobes = 5'h00;
        end
      end
      default: begin
        next_state = bwm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (rst) begin
      state      <= bwm_pkg::ST_IDLE;
      cnt        <= 3'h0;
      O_BUS_ADDR <= 24'h000000;
      O_BUS_DO   <= 8'h00;
      O_LD       <= 8'h00;
      strobes    <= 5'h00;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      O_BUS_ADDR <= next_bus_addr;
      O_BUS_DO   <= next_bus_do;
      O_LD       <= next_ld;
      strobes    <= next_strobes;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus strobes and local wait
  // ---------------------------------------------------------------------------
  logic on_bus;

  assign on_bus    = (state == bwm_pkg::ST_RUN);
  assign O_HOLD_OE = (state == bwm_pkg::ST_REQ) | (state == bwm_pkg::ST_ARB) | on_bus;
  assign O_SMEMR   = on_bus & (strobes[0] | strobes[4]);
  assign O_MWRT    = on_bus & strobes[1];
  assign O_SINP    = on_bus & strobes[2];
  assign O_SOUT    = on_bus & strobes[3];
  assign O_SM1     = on_bus & strobes[4];
  assign O_PDBIN   = on_bus & (strobes[0] | strobes[2] | strobes[4]);
  assign O_PWR     = on_bus & (strobes[1] | strobes[3]);

  // Held low from the start of a bus access until its data is latched
  always_comb begin
    O_READY = 1'b1;
    if (bus_cyc && state != bwm_pkg::ST_DONE) begin
      O_READY = 1'b0;
    end
    if (O_ROM_SEL && rom_wait_en && !rom_waited) begin
      O_READY = 1'b0;
    end
  end

endmodule // bus_window_master

// *** design/bwm_arbiter.sv ***
// Distributed 4-bit priority arbitration contender.
// Assumes the arbitration lines are wired-OR low; i_line_asserted is 1 where
// any master pulls a line low.
`timescale 1ns/1ps
module bwm_arbiter (
  // Control
  input  wire logic       i_enable,
  input  wire logic [3:0] i_priority,
  // Arbitration lines
  input  wire logic [3:0] i_line_asserted,
  output logic      [3:0] o_line_oe,
  // Result
  output logic            o_win
);

  // ---------------------------------------------------------------------------
  // Per-line drive: withdraw lower bits as soon as a higher bit is lost
  // ---------------------------------------------------------------------------
  logic [4:0] still_in;

  assign still_in[4] = i_enable;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_line
      assign o_line_oe[g]  = still_in[g+1] & i_priority[g];
      assign still_in[g]   = still_in[g+1] & (i_priority[g] | ~i_line_asserted[g]);
    end
  endgenerate

  assign o_win = i_enable & (i_line_asserted == i_priority);

endmodule // bwm_arbiter

// *** design/bwm_pkg.sv ***
// Constants shared by the bus window master and its testbench.
// Assumes a single 10 MHz reference clock and synchronous active-high reset.
package bwm_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int ARB_SETTLE_NS  = 200;
  localparam int ARB_SETTLE_CYC = (ARB_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS      = 200;
  localparam int STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Local memory map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] IRQ_CONTROLLER_PORT_LOW   = 16'h8000;
  localparam logic [15:0] IRQ_CONTROLLER_PORT_HIGH  = 16'h8001;
  localparam logic [15:0] SET_REQUEST_LATCH         = 16'h8002;
  localparam logic [15:0] BUS_ADDRESS_MIDDLE        = 16'h8004;
  localparam logic [15:0] BUS_ADDRESS_UPPER         = 16'h8005;
  localparam logic [15:0] ACKNOWLEDGE_RESPONSE_BYTE = 16'h8007;
  localparam logic [1:0]  RAM_REGION                = 2'h0;
  localparam logic [1:0]  ROM_REGION                = 2'h1;
  localparam logic [1:0]  PERIPH_REGION             = 2'h2;
  localparam logic [1:0]  WINDOW_REGION             = 2'h3;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BUS_ADDRESS_RESET = 8'h00;
  localparam logic [7:0] RESPONSE_RESET    = 8'hff;

  // ---------------------------------------------------------------------------
  // Option switch positions (index = position - 1, closed reads 0)
  // ---------------------------------------------------------------------------
  localparam int OPT_ROM_WAIT  = 0;
  localparam int OPT_RESP_EN   = 1;
  localparam int OPT_PRI_MSB   = 2;
  localparam int OPT_PRI_LSB   = 5;
  localparam int OPT_SLAVE_CLR = 6;

  // ---------------------------------------------------------------------------
  // Request route jumper codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ROUTE_NMI = 4'h8;
  localparam logic [3:0] ROUTE_INT = 4'h9;

  // ---------------------------------------------------------------------------
  // Bus sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ  = 3'b001,
    ST_ARB  = 3'b010,
    ST_RUN  = 3'b011,
    ST_DONE = 3'b100
  } bus_state_t;

endpackage

// *** tb/bus_window_master_sva.sv ***
// Port checker for bus_window_master, bound into every instance.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module bwm_chk (
  // Watched ports
  input wire logic        I_REF_CLK,
  input wire logic        I_RST,
  input wire logic [15:0] I_LA,
  input wire logic [7:0]  I_LD,
  input wire logic        I_MEM_RD,
  input wire logic        I_MEM_WR,
  input wire logic        I_IO_RD,
  input wire logic        I_IO_WR,
  input wire logic        I_FETCH,
  input wire logic [7:0]  I_OPTION_SWITCH,
  input wire logic        I_SYS_SINTA,
  input wire logic        I_SYS_PDBIN,
  input wire logic        O_READY,
  input wire logic        O_RAM_SEL,
  input wire logic        O_ROM_SEL,
  input wire logic        O_IRQ_CTRL_SEL,
  input wire logic [23:0] O_BUS_ADDR,
  input wire logic [7:0]  O_BUS_DO,
  input wire logic        O_SMEMR,
  input wire logic        O_MWRT,
  input wire logic        O_SINP,
  input wire logic        O_SOUT,
  input wire logic        O_SM1,
  input wire logic        O_ACK_DATA_OE
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  sequence s_win_req; $rose(I_MEM_RD) && I_LA[15:14] == 2'h3; endsequence
  sequence s_rd_start; $rose(O_SMEMR); endsequence
  property p_wait; s_win_req |=> !O_READY; endproperty
  a_wait: assert property (p_wait) else $error("no wait");
  property p_rd_len; s_rd_start |-> O_SMEMR [*3]; endproperty
  a_rd_len: assert property (p_rd_len) else $error("short read");
  property p_mem_addr;
    (O_SMEMR || O_MWRT) |-> I_LA[15:14] == 2'h3 && O_BUS_ADDR[7:0] == I_LA[7:0];
  endproperty
  a_mem_addr: assert property (p_mem_addr) else $error("bad window cycle");
  property p_mem_dir;
    (O_SMEMR |-> I_MEM_RD) and (O_MWRT |-> I_MEM_WR && !O_SMEMR && O_BUS_DO == I_LD);
  endproperty
  a_mem_dir: assert property (p_mem_dir) else $error("bad mem dir");
  property p_fetch; O_SM1 |-> O_SMEMR && I_FETCH; endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch");
  property p_io_addr;
    (O_SINP || O_SOUT) |-> O_BUS_ADDR[23:16] == 8'h00 && O_BUS_ADDR[7:0] == I_LA[7:0];
  endproperty
  a_io_addr: assert property (p_io_addr) else $error("bad io addr");
  property p_io_dir; (O_SINP |-> I_IO_RD) and (O_SOUT |-> I_IO_WR && O_BUS_DO == I_LD); endproperty
  a_io_dir: assert property (p_io_dir) else $error("bad io dir");
  property p_io_local; (I_IO_RD || I_IO_WR) |-> !(O_RAM_SEL || O_ROM_SEL || O_IRQ_CTRL_SEL); endproperty
  a_io_local: assert property (p_io_local) else $error("io hit local");
  property p_ack; O_ACK_DATA_OE == (!I_OPTION_SWITCH[1] && I_SYS_SINTA && I_SYS_PDBIN); endproperty
  a_ack: assert property (p_ack) else $error("bad ack drive");
endmodule // bwm_chk

bind bus_window_master bwm_chk i_bwm_chk (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_LA(I_LA), .I_LD(I_LD),
  .I_MEM_RD(I_MEM_RD), .I_MEM_WR(I_MEM_WR), .I_IO_RD(I_IO_RD), .I_IO_WR(I_IO_WR),
  .I_FETCH(I_FETCH), .I_OPTION_SWITCH(I_OPTION_SWITCH), .I_SYS_SINTA(I_SYS_SINTA),
  .I_SYS_PDBIN(I_SYS_PDBIN), .O_READY(O_READY), .O_RAM_SEL(O_RAM_SEL), .O_ROM_SEL(O_ROM_SEL),
  .O_IRQ_CTRL_SEL(O_IRQ_CTRL_SEL), .O_BUS_ADDR(O_BUS_ADDR), .O_BUS_DO(O_BUS_DO),
  .O_SMEMR(O_SMEMR), .O_MWRT(O_MWRT), .O_SINP(O_SINP), .O_SOUT(O_SOUT), .O_SM1(O_SM1),
  .O_ACK_DATA_OE(O_ACK_DATA_OE)
);

// *** tb/s100_far_model.sv ***
// Far side of the bus: permanent master granting hold, slave memory and ports.
// Assumes strobe kind is {memory read, memory write, input, output}.
`timescale 1ns/1ps
module s100_far_model (
  // Clock
  input  wire logic        i_clk,
  // From the device, and i_slow from the bench
  input  wire logic        i_hold,
  input  wire logic [3:0]  i_dma_oe,
  input  wire logic [23:0] i_addr,
  input  wire logic [7:0]  i_do,
  input  wire logic [3:0]  i_kind,
  input  wire logic        i_m1,
  input  wire logic        i_slow,
  // To the device
  output logic             o_phlda,
  output logic      [3:0]  o_dma_asserted,
  output logic             o_rdy,
  output logic      [7:0]  o_di
);
  logic       [3:0]  cnt = 4'h0;
  logic              tog = 1'b0;
  logic       [23:0] last_addr = 24'h0;
  logic       [7:0]  last_data = 8'h0;
  logic       [3:0]  last_kind = 4'h0;
  logic              last_m1 = 1'b0;
  wire               rd = i_kind[3] | i_kind[1];
  // Only this device contends, so the wired-OR lines show its own drive
  assign o_dma_asserted = i_dma_oe;
  assign o_rdy = cnt >= (i_slow ? 4'h5 : 4'h0);
  // Released data lines toggle so a stale value cannot pass
  assign o_di = rd ? (i_addr[7:0] ^ i_addr[15:8] ^ i_addr[23:16] ^ 8'h3c) : {8{tog}} ^ 8'ha5;
  always @(posedge i_clk) begin
    tog <= ~tog;
    o_phlda <= i_hold;
    cnt <= (i_kind != 4'h0) ? cnt + 4'h1 : 4'h0;
    if (i_kind != 4'h0) begin
      last_addr <= i_addr;
      last_data <= rd ? o_di : i_do;
      last_kind <= i_kind;
      last_m1 <= i_m1;
    end
  end
endmodule // s100_far_model

// *** tb/tb_bus_window_master.sv ***
// Self-checking bench for bus_window_master against the far-side bus model.
// Assumes 10 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
module tb_bus_window_master;
  logic        clk, rst, mrd, mwr, ird, iwr, fetch, serial_output_line, latch_src, slow;
  logic        sout_s, pwr_s, sinta, pdbin, phlda, rdy, ready, restart, ram_sel, rom_sel;
  logic        irq_sel, hold, smemr, mwrt, sinp, sout, sm1, pdbin_o, pwr_o, ack_oe, nmi_oe;
  logic        int_oe, sclr_n;
  logic [15:0] la;
  logic [7:0]  ld, cp_sw, opt_sw, sys_a, ld_o, bus_do, bus_di, ack_data, vi_oe;
  logic [3:0]  route, dma_as, dma_oe;
  logic [23:0] bus_addr;
  int          n_fail = 0, n_compared = 0;

  bus_window_master i_bus_window_master (
    .I_REF_CLK(clk), .I_RST(rst), .I_LA(la), .I_LD(ld), .I_MEM_RD(mrd), .I_MEM_WR(mwr),
    .I_IO_RD(ird), .I_IO_WR(iwr), .I_FETCH(fetch), .I_SERIAL_OUTPUT_LINE(serial_output_line),
    .o_ld_unused_guard(), .O_LD(ld_o), .O_READY(ready), .O_RESTART75(restart),
    .O_RAM_SEL(ram_sel), .O_ROM_SEL(rom_sel), .O_IRQ_CTRL_SEL(irq_sel),
    .I_CALL_PORT_SWITCH(cp_sw), .I_OPTION_SWITCH(opt_sw), .I_REQUEST_ROUTE_JUMPERS(route),
    .I_ROUTE_FROM_LATCH(latch_src), .O_HOLD_OE(hold), .I_PHLDA(phlda), .I_DMA_ASSERTED(dma_as),
    .O_DMA_OE(dma_oe), .I_RDY(rdy), .O_BUS_ADDR(bus_addr), .O_BUS_DO(bus_do), .I_BUS_DI(bus_di),
    .O_SMEMR(smemr), .O_MWRT(mwrt), .O_SINP(sinp), .O_SOUT(sout), .O_SM1(sm1),
    .O_PDBIN(pdbin_o), .O_PWR(pwr_o), .I_SYS_A(sys_a), .I_SYS_SOUT(sout_s), .I_SYS_PWR(pwr_s),
    .I_SYS_SINTA(sinta), .I_SYS_PDBIN(pdbin), .I_SLAVE_CLR_N(sclr_n), .O_ACK_DATA(ack_data),
    .O_ACK_DATA_OE(ack_oe), .O_VI_OE(vi_oe), .O_NMI_OE(nmi_oe), .O_INT_OE(int_oe));

  s100_far_model i_s100_far_model (
    .i_clk(clk), .i_hold(hold), .i_dma_oe(dma_oe), .i_addr(bus_addr), .i_do(bus_do),
    .i_kind({smemr, mwrt, sinp, sout}), .i_m1(sm1), .i_slow(slow), .o_phlda(phlda),
    .o_dma_asserted(dma_as), .o_rdy(rdy), .o_di(bus_di));

  function automatic logic [7:0] exp_rd(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
  endfunction
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Kind 0 memory read, 1 memory write, 2 input, 3 output; strobe held until ready
  task automatic local_cyc(input logic [15:0] a, input logic [7:0] d, input int k,
                           output logic [7:0] q);
    int i;
    la = a;
    ld = d;
    {mrd, mwr, ird, iwr} = 4'h8 >> k;
    @(posedge clk);
    i = 0;
    @(negedge clk);
    while (ready !== 1'b1 && i < 200) begin
      @(negedge clk);
      i++;
    end
    if (i >= 200) begin
      n_fail++;
      $display("ERROR %0t local cycle hang", $time);
      test_done;
    end
    @(posedge clk);
    q = ld_o;
    #1 {mrd, mwr, ird, iwr, fetch} = 5'h00;
    tick;
  endtask

  task automatic t_power_map;
    logic [7:0] q;
    {mrd, sclr_n} = 2'h2;
    @(negedge clk) chk_bit(rom_sel, 1'b1);
    tick;
    mrd = 1'b0;
    tick;
    local_cyc(16'h4000, 8'h00, 0, q);
    mrd = 1'b1;
    la = 16'h0000;
    @(negedge clk) chk_bit(ram_sel, 1'b1);
    tick;
    opt_sw[6] = 1'b0;
    tick;
    @(negedge clk) chk_bit(rom_sel, 1'b1);
    tick;
    {mrd, sclr_n, opt_sw[6]} = 3'h3;
    tick;
    $display("test power_map done");
  endtask
  task automatic t_window;
    logic [7:0] q;
    local_cyc(bwm_pkg::BUS_ADDRESS_MIDDLE, 8'h12, 1, q);
    local_cyc(bwm_pkg::BUS_ADDRESS_UPPER, 8'h34, 1, q);
    local_cyc(16'hc0a5, 8'h5a, 1, q);
    chk_val(i_s100_far_model.last_addr, 24'h3412a5);
    chk_val({i_s100_far_model.last_kind, i_s100_far_model.last_data}, 12'h45a);
    slow = 1'b1;
    local_cyc(16'hff83, 8'h00, 0, q);
    chk_val(q, exp_rd(24'h341283));
    chk_val(i_s100_far_model.last_addr, 24'h341283);
    slow = 1'b0;
    fetch = 1'b1;
    local_cyc(16'hd083, 8'h00, 0, q);
    chk_bit(i_s100_far_model.last_m1, 1'b1);
    chk_val(q, exp_rd(24'h341283));
    $display("test window done");
  endtask
  task automatic t_io;
    logic [7:0] q;
    local_cyc(bwm_pkg::BUS_ADDRESS_MIDDLE, 8'h77, 1, q);
    local_cyc(16'h003c, 8'h99, 3, q);
    chk_val(i_s100_far_model.last_addr, 24'h00773c);
    chk_val({i_s100_far_model.last_kind, i_s100_far_model.last_data}, 12'h199);
    local_cyc(bwm_pkg::BUS_ADDRESS_MIDDLE, 8'h00, 2, q);
    chk_val(i_s100_far_model.last_addr, 24'h007704);
    chk_val(q, exp_rd(24'h007704));
    local_cyc(16'he001, 8'h00, 0, q);
    chk_val(i_s100_far_model.last_addr, 24'h347701);
    $display("test io done");
  endtask
  task automatic t_call_port;
    {sout_s, pwr_s, sys_a} = {2'h3, 8'hf1};
    @(negedge clk) chk_bit(restart, 1'b1);
    @(negedge clk) chk_bit(restart, 1'b0);
    tick;
    {sout_s, pwr_s} = 2'h0;
    tick;
    {sout_s, pwr_s, sys_a} = {2'h3, 8'hf2};
    @(negedge clk) chk_bit(restart, 1'b0);
    tick;
    {sout_s, pwr_s} = 2'h0;
    tick;
    $display("test call_port done");
  endtask
  task automatic t_request;
    logic [7:0] q;
    serial_output_line = 1'b1;
    for (int j = 0; j < 11; j++) begin
      route = 4'(j);
      @(negedge clk);
      chk_val({vi_oe, nmi_oe, int_oe}, (j < 8) ? 10'h4 << j : 10'h4 >> (j - 7));
      tick;
    end
    route = bwm_pkg::ROUTE_INT;
    serial_output_line = 1'b0;
    @(negedge clk) chk_bit(int_oe, 1'b0);
    tick;
    latch_src = 1'b1;
    local_cyc(bwm_pkg::SET_REQUEST_LATCH, 8'h00, 0, q);
    chk_bit(int_oe, 1'b1);
    local_cyc(bwm_pkg::ACKNOWLEDGE_RESPONSE_BYTE, 8'hc7, 1, q);
    {sinta, pdbin} = 2'h3;
    @(negedge clk) chk_val({ack_oe, ack_data}, 12'h1c7);
    tick;
    {sinta, pdbin} = 2'h0;
    @(negedge clk) chk_bit(int_oe, 1'b0);
    tick;
    opt_sw[1] = 1'b1;
    {sinta, pdbin} = 2'h3;
    @(negedge clk) chk_bit(ack_oe, 1'b0);
    tick;
    {sinta, pdbin} = 2'h0;
    $display("test request done");
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst, sclr_n, mrd, mwr, ird, iwr, fetch, serial_output_line, latch_src, slow} = 10'h300;
    {sout_s, pwr_s, sinta, pdbin, la, ld, sys_a, route} = '0;
    cp_sw = 8'hf1;
    opt_sw = 8'hd5;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    t_power_map;
    t_window;
    t_io;
    t_call_port;
    t_request;
    test_done;
  end
endmodule // tb_bus_window_master
